// >>> inc/pspc_defines.vh
// pspc_defines.vh: register offsets, field positions, reset values and timing counts
// assumes a 20 MHz core clock and an 8-bit register port
`ifndef PSPC_DEFINES_VH
`define PSPC_DEFINES_VH
`define PSPC_ADDR_UV_CFG 3'h0
`define PSPC_ADDR_OC_CFG 3'h1
`define PSPC_ADDR_AC_CFG 3'h2
`define PSPC_ADDR_DC_CFG 3'h3
`define PSPC_ADDR_STATUS 3'h4
`define PSPC_ADDR_CLEAR 3'h5
`define PSPC_ADDR_IRQ_EN 3'h6
`define PSPC_UV_EN_BIT 7
`define PSPC_UV_THR_MSB 5
`define PSPC_UV_MASK 8'hBF
`define PSPC_OC_EN_BIT 7
`define PSPC_OC_LEB_MSB 6
`define PSPC_OC_LEB_LSB 5
`define PSPC_OC_THR_MSB 4
`define PSPC_OC_MASK 8'hFF
`define PSPC_AC_MASK 8'h7F
`define PSPC_DC_EN_BIT 7
`define PSPC_DC_MASK 8'h8F
`define PSPC_CFG_RESET 8'h00
`define PSPC_ST_UV_BIT 0
`define PSPC_ST_OC_BIT 1
`define PSPC_CLK_MHZ 20
`define PSPC_LEB0_NS 114
`define PSPC_LEB1_NS 213
`define PSPC_LEB2_NS 400
`define PSPC_LEB3_NS 780
// least times round up
`define PSPC_NS_CYC(ns) (((ns) * `PSPC_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/pspc_sync.v
// pspc_sync.v: three-stage input synchroniser, change accepted when stages two and three agree
// assumes the input is asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module pspc_sync (
  input wire core_clk_i,
  input wire rst_i,
  input wire async_i,
  output reg sync_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_o <= s3;
      end
    end
  end
endmodule // pspc_sync
`default_nettype wire

// >>> rtl/pspc_blank.v
// pspc_blank.v: leading-edge blanking timer for the overcurrent comparator
// assumes high-side conduction start is a same-clock level
`timescale 1ns/1ps
`include "pspc_defines.vh"
`default_nettype none
module pspc_blank (
  input wire core_clk_i,
  input wire rst_i,
  input wire conduct_i,
  input wire [1:0] sel_i,
  output wire blanked_o
);
  localparam integer C0_I = `PSPC_NS_CYC(`PSPC_LEB0_NS);
  localparam integer C1_I = `PSPC_NS_CYC(`PSPC_LEB1_NS);
  localparam integer C2_I = `PSPC_NS_CYC(`PSPC_LEB2_NS);
  localparam integer C3_I = `PSPC_NS_CYC(`PSPC_LEB3_NS);
  localparam [5:0] C0 = C0_I[5:0];
  localparam [5:0] C1 = C1_I[5:0];
  localparam [5:0] C2 = C2_I[5:0];
  localparam [5:0] C3 = C3_I[5:0];
  reg [5:0] cnt;
  reg conduct_d;
  reg [5:0] load;
  always @* begin
    case (sel_i)
      2'h0: load = C0;
      2'h1: load = C1;
      2'h2: load = C2;
      default: load = C3;
    endcase
  end
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 6'h00;
      conduct_d <= 1'b0;
    end else begin
      conduct_d <= conduct_i;
      if (conduct_i && !conduct_d) begin
        cnt <= load - 6'h01;
      end else if (!conduct_i) begin
        cnt <= 6'h00;
      end else if (cnt != 6'h00) begin
        cnt <= cnt - 6'h01;
      end
    end
  end
  // blanking covers the first edge and the loaded count
  assign blanked_o = (conduct_i && !conduct_d) || (cnt != 6'h00);
endmodule // pspc_blank
`default_nettype wire

// >>> rtl/pspc_top.v
// pspc_top.v: protection and current-sense configuration registers with flags and interrupt
// assumes a one-cycle register port, comparator pins asynchronous, switching clock on core clock
//
// Notes on behaviour
// - input low flag sets while the supply sits below the threshold
// - input low flag clears by itself once the supply recovers
// - undervoltage detection works only while its enable bit 7 is one
// - input low flag sets regardless of interrupt enables
// - undervoltage threshold is a six-bit log code in bits 5-0
// - overcurrent sets its flag and ends the high-side pulse at once
// - high-side drive starts again at the next switching cycle
// - persisting overcurrent ends each new pulse again
// - software clears overcurrent flag; it re-sets unless a clean cycle passed
// - overcurrent flag sets regardless of interrupt enables
// - detection is blanked at each conduction start, 114 to 780 ns
// - overcurrent detection works only while its enable bit 7 is one
// - five-bit drop threshold in bits 4-0, 160 to 625 mV
// - four-bit AC sense gain code in bits 3-0
// - unimplemented bits read zero, reserved bits kept as fields
// - DC gain enable routes the gained sense signal into the loop
// - three-bit DC sense gain code in bits 2-0
`timescale 1ns/1ps
`include "pspc_defines.vh"
`default_nettype none
module pspc_top (
  input wire core_clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire supply_low_i,
  input wire overcurrent_i,
  input wire cycle_start_i,
  input wire pwm_i,
  output wire high_drive_o,
  output wire [5:0] undervoltage_threshold_o,
  output wire undervoltage_enable_o,
  output wire [4:0] overcurrent_threshold_o,
  output wire overcurrent_enable_o,
  output wire [3:0] ac_gain_select_o,
  output wire [2:0] dc_gain_select_o,
  output wire dc_gain_loop_enable_o,
  output wire irq_o
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [7:0] uv_cfg;
  reg [7:0] oc_cfg;
  reg [7:0] ac_cfg;
  reg [7:0] dc_cfg;
  reg [1:0] irq_en;
  reg [1:0] status;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_cfg <= `PSPC_CFG_RESET;
      oc_cfg <= `PSPC_CFG_RESET;
      ac_cfg <= `PSPC_CFG_RESET;
      dc_cfg <= `PSPC_CFG_RESET;
      irq_en <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `PSPC_ADDR_UV_CFG: uv_cfg <= wdata_i & `PSPC_UV_MASK;
        `PSPC_ADDR_OC_CFG: oc_cfg <= wdata_i & `PSPC_OC_MASK;
        `PSPC_ADDR_AC_CFG: ac_cfg <= wdata_i & `PSPC_AC_MASK;
        `PSPC_ADDR_DC_CFG: dc_cfg <= wdata_i & `PSPC_DC_MASK;
        `PSPC_ADDR_IRQ_EN: irq_en <= wdata_i[1:0];
        default: irq_en <= irq_en;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign undervoltage_threshold_o = uv_cfg[`PSPC_UV_THR_MSB:0];
  assign undervoltage_enable_o = uv_cfg[`PSPC_UV_EN_BIT];
  assign overcurrent_threshold_o = oc_cfg[`PSPC_OC_THR_MSB:0];
  assign overcurrent_enable_o = oc_cfg[`PSPC_OC_EN_BIT];
  assign ac_gain_select_o = ac_cfg[3:0];
  assign dc_gain_select_o = dc_cfg[2:0];
  assign dc_gain_loop_enable_o = dc_cfg[`PSPC_DC_EN_BIT];
  // ----------------------------------------------------------------
  // comparator inputs
  // ----------------------------------------------------------------
  wire low_s;
  wire oc_s;
  wire blanked;
  pspc_sync u_sync_low (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(supply_low_i),
    .sync_o(low_s)
  );
  pspc_sync u_sync_oc (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(overcurrent_i),
    .sync_o(oc_s)
  );
  // ----------------------------------------------------------------
  // high-side drive and cycle-by-cycle limit
  // ----------------------------------------------------------------
  reg terminated;
  reg clean_cycle;
  wire oc_hit;
  pspc_blank u_blank (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .conduct_i(pwm_i && !terminated),
    .sel_i(oc_cfg[`PSPC_OC_LEB_MSB:`PSPC_OC_LEB_LSB]),
    .blanked_o(blanked)
  );
  assign oc_hit = oc_cfg[`PSPC_OC_EN_BIT] && oc_s && pwm_i && !blanked;
  // drive is cut in the same cycle as the hit
  assign high_drive_o = pwm_i && !terminated && !oc_hit;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      terminated <= 1'b0;
      clean_cycle <= 1'b0;
    end else begin
      if (cycle_start_i) begin
        // each new cycle restarts the drive; blanking then re-arms detection
        terminated <= 1'b0;
      end else if (oc_hit) begin
        terminated <= 1'b1;
      end
      if (oc_hit) begin
        clean_cycle <= 1'b0;
      end else if (cycle_start_i && !terminated) begin
        clean_cycle <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // status flags, interrupt enables not involved in setting
  // ----------------------------------------------------------------
  wire clr_wr;
  wire uv_now;
  assign clr_wr = wr_i && (addr_i == `PSPC_ADDR_CLEAR);
  assign uv_now = uv_cfg[`PSPC_UV_EN_BIT] && low_s;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status <= 2'h0;
    end else begin
      // input low flag follows its condition, clear write has no effect
      status[`PSPC_ST_UV_BIT] <= uv_now;
      if (oc_hit || (!clean_cycle && status[`PSPC_ST_OC_BIT])) begin
        // set wins over clear; re-set while no clean cycle has passed
        status[`PSPC_ST_OC_BIT] <= 1'b1;
      end else if (clr_wr && wdata_i[`PSPC_ST_OC_BIT]) begin
        status[`PSPC_ST_OC_BIT] <= 1'b0;
      end
    end
  end
  assign irq_o = |(status & irq_en);
  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `PSPC_ADDR_UV_CFG: rdata_o <= uv_cfg;
        `PSPC_ADDR_OC_CFG: rdata_o <= oc_cfg;
        `PSPC_ADDR_AC_CFG: rdata_o <= ac_cfg;
        `PSPC_ADDR_DC_CFG: rdata_o <= dc_cfg;
        `PSPC_ADDR_STATUS: rdata_o <= {6'h00, status};
        `PSPC_ADDR_IRQ_EN: rdata_o <= {6'h00, irq_en};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // pspc_top
`default_nettype wire

// >>> testbench/pspc_top_asserts.sv
// pspc_top_asserts.sv: port checker for pspc_top
// assumes the one-cycle register port of pspc_top
`timescale 1ns/1ps
`default_nettype none
module pspc_top_asserts (
  input wire core_clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire pwm_i,
  input wire cycle_start_i,
  input wire high_drive_o,
  input wire [5:0] undervoltage_threshold_o,
  input wire undervoltage_enable_o,
  input wire [4:0] overcurrent_threshold_o,
  input wire overcurrent_enable_o,
  input wire [3:0] ac_gain_select_o,
  input wire [2:0] dc_gain_select_o,
  input wire dc_gain_loop_enable_o
);
  // --
  // checks
  // --
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  a_uv_cfg_store: assert property (wr_i && addr_i == 3'h0 |=>
    {undervoltage_enable_o, 1'b0, undervoltage_threshold_o} == ($past(wdata_i) & 8'hBF)) else $error("uv cfg");
  a_oc_cfg_store: assert property (wr_i && addr_i == 3'h1 |=>
    {overcurrent_enable_o, 2'b00, overcurrent_threshold_o} == ($past(wdata_i) & 8'h9F)) else $error("oc cfg");
  a_ac_cfg_store: assert property (wr_i && addr_i == 3'h2 |=>
    {4'h0, ac_gain_select_o} == ($past(wdata_i) & 8'h0F)) else $error("ac cfg");
  a_dc_cfg_store: assert property (wr_i && addr_i == 3'h3 |=>
    {dc_gain_loop_enable_o, 4'h0, dc_gain_select_o} == ($past(wdata_i) & 8'h87)) else $error("dc cfg");
  a_cfg_hold: assert property (!wr_i |=> $stable({undervoltage_threshold_o, ac_gain_select_o}))
    else $error("config changed");
  a_drive_cut_hold: assert property ($fell(high_drive_o) && pwm_i && !cycle_start_i |=> !high_drive_o)
    else $error("drive back early");
  a_ac_read_back: assert property (rd_i && addr_i == 3'h2 |=>
    rdata_o[7] == 1'b0 && rdata_o[3:0] == ac_gain_select_o) else $error("ac read");
endmodule // pspc_top_asserts
bind pspc_top pspc_top_asserts chk_u (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pwm_i,
  .cycle_start_i, .high_drive_o, .undervoltage_threshold_o, .undervoltage_enable_o, .overcurrent_threshold_o,
  .overcurrent_enable_o, .ac_gain_select_o, .dc_gain_select_o, .dc_gain_loop_enable_o);
`default_nettype wire

// >>> testbench/test_power_stage_protect_config.sv
// test_power_stage_protect_config.sv: register-port bench for pspc_top
// assumes the checker binds itself to the design
`timescale 1ns/1ps
`default_nettype none
module test_power_stage_protect_config;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, low = 1'b0, oc = 1'b0, cs = 1'b0, pwm = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] mask [4] = '{8'hBF, 8'hFF, 8'h7F, 8'h8F};
  wire [7:0] rdata;
  wire drive, irq;
  int fail_count = 0, checked = 0, cycles = 0;
  pspc_top dut_u (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .supply_low_i(low), .overcurrent_i(oc), .cycle_start_i(cs), .pwm_i(pwm),
    .high_drive_o(drive), .undervoltage_threshold_o(), .undervoltage_enable_o(), .overcurrent_threshold_o(),
    .overcurrent_enable_o(), .ac_gain_select_o(), .dc_gain_select_o(), .dc_gain_loop_enable_o(), .irq_o(irq));
  // --
  // tasks
  // --
  initial forever #25 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    tick(1);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    tick(1);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic pins(input logic [1:0] e);
    @(negedge clk);
    chk({6'h00, irq, drive}, {6'h00, e});
  endtask
  task automatic pulse;
    tick(1);
    cs <= 1'b1;
    tick(1);
    cs <= 1'b0;
  endtask
  initial begin
    tick(5);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
    for (int a = 0; a < 4; a++) begin
      wr_reg(a[2:0], 8'hFF);
      rd_reg(a[2:0], mask[a]);
      wr_reg(a[2:0], 8'h5A);
      rd_reg(a[2:0], 8'h5A & mask[a]);
    end
    wr_reg(3'h7, 8'hFF);
    wr_reg(3'h4, 8'hFF);
    rd_reg(3'h7, 8'h00);
    rd_reg(3'h4, 8'h00);
    wr_reg(3'h0, 8'h80);
    low <= 1'b1;
    tick(8);
    rd_reg(3'h4, 8'h01);
    pins(2'b00);
    wr_reg(3'h6, 8'h01);
    pins(2'b10);
    wr_reg(3'h5, 8'h01);
    rd_reg(3'h4, 8'h01);
    wr_reg(3'h6, 8'h00);
    pins(2'b00);
    tick(1);
    low <= 1'b0;
    tick(8);
    rd_reg(3'h4, 8'h00);
    wr_reg(3'h0, 8'h00);
    low <= 1'b1;
    tick(8);
    rd_reg(3'h4, 8'h00);
    wr_reg(3'h1, 8'h80);
    oc <= 1'b1;
    low <= 1'b0;
    pulse();
    pwm <= 1'b1;
    pins(2'b01);
    tick(6);
    pins(2'b00);
    rd_reg(3'h4, 8'h02);
    wr_reg(3'h5, 8'h02);
    rd_reg(3'h4, 8'h02);
    pulse();
    pins(2'b01);
    tick(3);
    pins(2'b00);
    tick(1);
    oc <= 1'b0;
    tick(6);
    pulse();
    pins(2'b01);
    pulse();
    wr_reg(3'h5, 8'h02);
    rd_reg(3'h4, 8'h00);
    tick(1);
    pwm <= 1'b0;
    wr_reg(3'h1, 8'hE0);
    oc <= 1'b1;
    pulse();
    pwm <= 1'b1;
    tick(10);
    pins(2'b01);
    tick(8);
    pins(2'b00);
    wr_reg(3'h1, 8'h60);
    pulse();
    pins(2'b01);
    stop_test();
  end
endmodule // test_power_stage_protect_config
`default_nettype wire
